// ===== verilog/mmn_exec.sv
// Four-phase decode and execute unit for literal load, store, multiply and negate instructions.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "mmn_map.svh"

// Function
// - Upper seven bits 0110111 copy the accumulator to the addressed register, no flags.
// - Bank bit clear uses the access bank; set uses the bank select pointer.
// - Bank bit clear, extended set enabled and address up to 95 use indexed offset.
// - Upper byte 0D multiplies accumulator by literal, unsigned; accumulator unchanged.
// - Multiplies write the 16-bit product, high byte high, low byte low.
// - Upper seven bits 0000001 multiply accumulator by register; both left unchanged.
// - Multiplies change no status flag, not even zero.
// - Register multiply reads in phase two, computes in three, writes in four.
// - Upper seven bits 0110110 replace the register with its two's complement.
// - Negation updates negative, overflow, carry, digit carry and zero flags.
module mmn_exec
    import mmn_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [15:0] INSTR,
    input wire logic [11:0] INDEX_BASE,
    input wire logic [7:0] DMEM_RDATA,
    output mmn_dmem_s DMEM,
    output mmn_phase_e PHASE,
    output logic [7:0] ACCUM,
    output logic [15:0] PRODUCT,
    output mmn_flags_s FLAGS
);

    function automatic mmn_op_e decode_op(input logic [15:0] word);
        mmn_op_e op;
        op = MMN_OP_NONE;
        if (word == `MMN_RST_WORD || word[15:12] == `MMN_OPC4_SKIP) begin
            op = MMN_OP_NONE;
        end else if (word[15:8] == `MMN_OPC_LOAD_LIT) begin
            op = MMN_OP_LOAD;
        end else if (word[15:8] == `MMN_OPC_MUL_LIT) begin
            op = MMN_OP_MULL;
        end else if (word[15:9] == `MMN_OPC7_STORE) begin
            op = MMN_OP_STORE;
        end else if (word[15:9] == `MMN_OPC7_MUL_REG) begin
            op = MMN_OP_MULR;
        end else if (word[15:9] == `MMN_OPC7_NEGATE) begin
            op = MMN_OP_NEG;
        end
        return op;
    endfunction

    function automatic logic [11:0] resolve_addr(input logic [15:0] word, input logic [3:0] bank,
                                                 input logic ext, input logic [11:0] base);
        logic [11:0] addr;
        addr = {bank, word[7:0]};
        if (word[8] == 1'b0) begin
            if (ext && word[7:0] <= `MMN_ACCESS_LIMIT) begin
                addr = base + {4'h0, word[7:0]};
            end else if (word[7:0] <= `MMN_ACCESS_LIMIT) begin
                addr = {`MMN_ACCESS_LOW_BANK, word[7:0]};
            end else begin
                addr = {`MMN_ACCESS_HIGH_BANK, word[7:0]};
            end
        end
        return addr;
    endfunction

    function automatic logic uses_register(input mmn_op_e op);
        return op == MMN_OP_STORE || op == MMN_OP_MULR || op == MMN_OP_NEG;
    endfunction

    logic rst_meta;
    logic rst_n;

    // The pin is released through two flops so no register leaves reset on a metastable edge.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Bus-side state.
    logic [1:0] ctrl;
    logic [3:0] bank;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [1:0] next_ctrl;
    logic [3:0] next_bank;
    logic setup;
    logic wr_hit;

    // Execute-side state.
    mmn_phase_e next_phase;
    logic [15:0] ir;
    logic [15:0] next_ir;
    mmn_op_e op;
    mmn_op_e next_op;
    logic [7:0] operand;
    logic [7:0] next_operand;
    logic [7:0] result;
    logic [7:0] next_result;
    logic [15:0] prod_calc;
    logic [15:0] next_prod_calc;
    mmn_flags_s flags_calc;
    mmn_flags_s next_flags_calc;
    mmn_dmem_s next_dmem;
    logic [7:0] next_accum;
    logic [15:0] next_product;
    mmn_flags_s next_flags;
    mmn_op_e fetched_op;

    logic [15:0] alu_product;
    logic [7:0] alu_negated;
    mmn_flags_s alu_flags;

    mmn_alu u_alu (
        .acc(ACCUM),
        .operand(operand),
        .product(alu_product),
        .negated(alu_negated),
        .neg_flags(alu_flags)
    );

    // Every access answers in its first access cycle, so the master never waits more than one.
    always_comb begin
        setup = PSEL && !PENABLE;
        wr_hit = PSEL && PENABLE && PREADY && PWRITE;
        next_pready = setup;
        next_pslverr = 1'b0;
        next_prdata = `MMN_RST_WORD32;
        next_ctrl = ctrl;
        next_bank = bank;
        if (setup) begin
            if (PADDR == `MMN_OFS_CTRL) begin
                next_prdata = {30'h00000000, ctrl};
            end else if (PADDR == `MMN_OFS_BANK) begin
                next_prdata = {28'h0000000, bank};
            end else if (PADDR == `MMN_OFS_ACC) begin
                next_prdata = {24'h000000, ACCUM};
            end else if (PADDR == `MMN_OFS_PROD) begin
                next_prdata = {16'h0000, PRODUCT};
            end else if (PADDR == `MMN_OFS_FLAGS) begin
                next_prdata = {27'h0000000, FLAGS};
            end else if (PADDR == `MMN_OFS_INSTR) begin
                next_prdata = {16'h0000, ir};
            end else begin
                next_pslverr = 1'b1;
            end
        end
        // Writes to read-only offsets are dropped quietly; only unmapped offsets answer with an error.
        if (wr_hit) begin
            if (PADDR == `MMN_OFS_CTRL) begin
                next_ctrl = PWDATA[1:0];
            end else if (PADDR == `MMN_OFS_BANK) begin
                next_bank = PWDATA[3:0];
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA <= `MMN_RST_WORD32;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            ctrl <= `MMN_RST_CTRL;
            bank <= `MMN_RST_BANK;
        end else begin
            PRDATA <= next_prdata;
            PREADY <= next_pready;
            PSLVERR <= next_pslverr;
            ctrl <= next_ctrl;
            bank <= next_bank;
        end
    end

    // Four phases per instruction cycle; each phase is one core clock.
    always_comb begin
        fetched_op = decode_op(INSTR);
        next_phase = PHASE;
        next_ir = ir;
        next_op = op;
        next_operand = operand;
        next_result = result;
        next_prod_calc = prod_calc;
        next_flags_calc = flags_calc;
        next_dmem = DMEM;
        next_accum = ACCUM;
        next_product = PRODUCT;
        next_flags = FLAGS;
        case (PHASE)
            MMN_Q1: begin
                next_phase = MMN_Q2;
                next_ir = INSTR;
                next_op = ctrl[`MMN_CTRL_RUN_BIT] ? fetched_op : MMN_OP_NONE;
                next_dmem.addr = resolve_addr(INSTR, bank, ctrl[`MMN_CTRL_EXT_BIT], INDEX_BASE);
                next_dmem.re = ctrl[`MMN_CTRL_RUN_BIT] && uses_register(fetched_op);
                next_dmem.we = 1'b0;
            end
            MMN_Q2: begin
                next_phase = MMN_Q3;
                next_dmem.re = 1'b0;
                if (op == MMN_OP_MULR || op == MMN_OP_NEG) begin
                    next_operand = DMEM_RDATA;
                end else if (op == MMN_OP_MULL) begin
                    next_operand = ir[7:0];
                end
            end
            MMN_Q3: begin
                next_phase = MMN_Q4;
                next_prod_calc = alu_product;
                next_flags_calc = alu_flags;
                next_result = (op == MMN_OP_NEG) ? alu_negated : ACCUM;
                next_dmem.wdata = (op == MMN_OP_NEG) ? alu_negated : ACCUM;
                next_dmem.we = (op == MMN_OP_STORE) || (op == MMN_OP_NEG);
            end
            MMN_Q4: begin
                next_phase = MMN_Q1;
                next_dmem.we = 1'b0;
                case (op)
                    MMN_OP_LOAD: begin
                        next_accum = ir[7:0];
                    end
                    MMN_OP_MULL, MMN_OP_MULR: begin
                        next_product = prod_calc;
                        next_flags = FLAGS;
                        next_accum = ACCUM;
                    end
                    MMN_OP_NEG: begin
                        next_flags = flags_calc;
                    end
                    MMN_OP_STORE: begin
                        next_flags = FLAGS;
                    end
                    default: begin
                        next_accum = ACCUM;
                    end
                endcase
            end
            default: begin
                next_phase = MMN_Q1;
            end
        endcase
    end

    // Every result is registered here so each output of the unit comes straight from a flop.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            PHASE <= MMN_Q1;
            ir <= `MMN_RST_WORD;
            op <= MMN_OP_NONE;
            operand <= `MMN_RST_BYTE;
            result <= `MMN_RST_BYTE;
            prod_calc <= `MMN_RST_WORD;
            flags_calc <= '0;
            DMEM <= '0;
            ACCUM <= `MMN_RST_BYTE;
            PRODUCT <= `MMN_RST_WORD;
            FLAGS <= '0;
        end else begin
            PHASE <= next_phase;
            ir <= next_ir;
            op <= next_op;
            operand <= next_operand;
            result <= next_result;
            prod_calc <= next_prod_calc;
            flags_calc <= next_flags_calc;
            DMEM <= next_dmem;
            ACCUM <= next_accum;
            PRODUCT <= next_product;
            FLAGS <= next_flags;
        end
    end

endmodule

// ===== verilog/mmn_map.svh
// Register offsets, opcode patterns, phase codes and reset values for the move, multiply and negate unit.
`ifndef MMN_MAP_SVH
`define MMN_MAP_SVH

// APB register byte offsets.
`define MMN_OFS_CTRL 12'h000
`define MMN_OFS_BANK 12'h004
`define MMN_OFS_ACC 12'h008
`define MMN_OFS_PROD 12'h00c
`define MMN_OFS_FLAGS 12'h010
`define MMN_OFS_INSTR 12'h014

// Control register bit positions.
`define MMN_CTRL_EXT_BIT 0
`define MMN_CTRL_RUN_BIT 1

// Opcode patterns on the upper byte, the upper seven bits or the upper four bits.
`define MMN_OPC_LOAD_LIT 8'h0e
`define MMN_OPC_MUL_LIT 8'h0d
`define MMN_OPC7_STORE 7'h37
`define MMN_OPC7_MUL_REG 7'h01
`define MMN_OPC7_NEGATE 7'h36
`define MMN_OPC4_SKIP 4'hf

// Addressing constants.
`define MMN_ACCESS_LIMIT 8'h5f
`define MMN_ACCESS_HIGH_BANK 4'hf
`define MMN_ACCESS_LOW_BANK 4'h0

// Phase codes within one instruction cycle.
`define MMN_PH_Q1 2'h0
`define MMN_PH_Q2 2'h1
`define MMN_PH_Q3 2'h2
`define MMN_PH_Q4 2'h3

// Reset values.
`define MMN_RST_BYTE 8'h00
`define MMN_RST_WORD 16'h0000
`define MMN_RST_ADDR 12'h000
`define MMN_RST_BANK 4'h0
`define MMN_RST_CTRL 2'h0
`define MMN_RST_WORD32 32'h00000000

`endif

// ===== verilog/mmn_pkg.sv
// Types shared by the move, multiply and negate unit.
package mmn_pkg;

    typedef enum logic [2:0] {
        MMN_OP_NONE = 3'b000,
        MMN_OP_LOAD = 3'b001,
        MMN_OP_STORE = 3'b010,
        MMN_OP_MULL = 3'b011,
        MMN_OP_MULR = 3'b100,
        MMN_OP_NEG = 3'b101
    } mmn_op_e;

    typedef enum logic [1:0] {
        MMN_Q1 = 2'b00,
        MMN_Q2 = 2'b01,
        MMN_Q3 = 2'b10,
        MMN_Q4 = 2'b11
    } mmn_phase_e;

    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } mmn_flags_s;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic re;
        logic we;
    } mmn_dmem_s;

endpackage

// ===== verilog/mmn_alu.sv
// Combinational data path: unsigned multiply and two's-complement negation with flags.
`timescale 1ns/1ps
`include "mmn_map.svh"

module mmn_alu
    import mmn_pkg::*;
(
    input wire logic [7:0] acc,
    input wire logic [7:0] operand,
    output logic [15:0] product,
    output logic [7:0] negated,
    output mmn_flags_s neg_flags
);

    logic [8:0] full_sum;
    logic [4:0] low_sum;

    always_comb begin
        product = {8'h00, acc} * {8'h00, operand};
        full_sum = {1'b0, ~operand} + 9'h001;
        low_sum = {1'b0, ~operand[3:0]} + 5'h01;
        negated = full_sum[7:0];
        neg_flags.n = full_sum[7];
        neg_flags.z = (full_sum[7:0] == `MMN_RST_BYTE);
        neg_flags.c = full_sum[8];
        neg_flags.dc = low_sum[4];
        neg_flags.ov = (operand[7] == 1'b1) && (full_sum[7] == 1'b1);
    end

endmodule

// ===== verification/mmn_dmem_model.sv
// Banked data memory model answering the unit's data port.
`timescale 1ns/1ps
module mmn_dmem_model
    import mmn_pkg::*;
(
    input wire logic clk,
    input wire mmn_dmem_s dmem,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:4095];
    logic [7:0] last;
    initial begin
        last = 8'h00;
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'h00;
        end
    end
    always @(posedge clk) begin
        if (dmem.we) begin
            mem[dmem.addr] <= dmem.wdata;
        end
        if (dmem.re) begin
            last <= mem[dmem.addr];
        end
    end
    // Outside a read the bus shows the inverse, so a stale capture cannot pass.
    assign rdata = dmem.re ? mem[dmem.addr] : ~last;
endmodule

// ===== verification/mmn_exec_props.sv
// Port checker for the move, multiply and negate unit.
`timescale 1ns/1ps
module mmn_exec_props
    import mmn_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [11:0] PADDR,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [15:0] INSTR,
    input wire logic [7:0] DMEM_RDATA,
    input wire mmn_dmem_s DMEM,
    input wire mmn_phase_e PHASE,
    input wire logic [7:0] ACCUM,
    input wire logic [15:0] PRODUCT,
    input wire mmn_flags_s FLAGS
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    logic [15:0] i1, i2, i3, i4;
    logic [7:0] r1, r2;
    always_ff @(posedge CORE_CLK) begin
        i1 <= INSTR;
        i2 <= i1;
        i3 <= i2;
        i4 <= i3;
        r1 <= DMEM_RDATA;
        r2 <= r1;
    end
    ready_next_a: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready after setup");
    err_unmapped_a: assert property (PREADY && PADDR > 12'h014 |-> PSLVERR) else $error("no error");
    lit_load_a: assert property ($changed(ACCUM) |-> i4[15:8] == 8'h0e && ACCUM == i4[7:0])
        else $error("bad accumulator change");
    store_data_a: assert property (DMEM.we && i3[15:9] == 7'h37 |-> DMEM.wdata == ACCUM)
        else $error("bad store data");
    prod_source_a: assert property ($changed(PRODUCT) |-> i4[15:8] == 8'h0d || i4[15:9] == 7'h01)
        else $error("bad product change");
    flags_source_a: assert property ($changed(FLAGS) |-> i4[15:9] == 7'h36)
        else $error("bad flag change");
    read_phase_a: assert property (DMEM.re |-> PHASE == MMN_Q2) else $error("read off phase");
    write_phase_a: assert property (DMEM.we |-> PHASE == MMN_Q4) else $error("write off phase");
    neg_data_a: assert property (DMEM.we && i3[15:9] == 7'h36 |-> DMEM.wdata == 8'h00 - r2)
        else $error("bad negation");
    nop_quiet_a: assert property (PHASE == MMN_Q1 && (INSTR == 16'h0000 || INSTR[15:12] == 4'hf)
        |=> !DMEM.re ##2 !DMEM.we) else $error("idle word touched memory");
endmodule
bind mmn_exec mmn_exec_props chk (.*);

// ===== verification/mmn_exec_bench.sv
// Register-level bench for the move, multiply and negate unit.
`timescale 1ns/1ps
module mmn_exec_bench;
    import mmn_pkg::*;
    logic CORE_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, e;
    logic [11:0] PADDR, INDEX_BASE;
    logic [31:0] PWDATA, PRDATA, q;
    logic [15:0] INSTR;
    logic [7:0] DMEM_RDATA, x, r;
    logic [7:0] tab [0:3] = '{8'h3a, 8'h00, 8'h80, 8'h01};
    mmn_dmem_s DMEM;
    mmn_phase_e PHASE;
    logic [7:0] ACCUM;
    logic [15:0] PRODUCT;
    mmn_flags_s FLAGS;
    int err_count = 0;
    int total_checks = 0;
    mmn_exec uut (.*);
    mmn_dmem_model mem (.clk(CORE_CLK), .dmem(DMEM), .rdata(DMEM_RDATA));
    initial begin
        CORE_CLK = 0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge CORE_CLK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1;
        n = 0;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
        if (n >= 20) begin
            err_count++;
            give_verdict;
        end
    endtask
    // The word goes out at the edge that closes the fourth phase and stands for the first phase only.
    task exec(input logic [15:0] w);
        int n;
        n = 0;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (PHASE !== MMN_Q4 && n < 8);
        if (n >= 8) begin
            err_count++;
            give_verdict;
        end
        INSTR <= w;
        @(posedge CORE_CLK);
        INSTR <= 16'h0000;
        repeat (3) @(posedge CORE_CLK);
        #1;
    endtask
    initial begin
        {RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, INSTR, INDEX_BASE} = '0;
        repeat (20) @(posedge CORE_CLK);
        RST_N <= 1;
        repeat (6) @(posedge CORE_CLK);
        cmp("acc", 16'h0, ACCUM);
        cmp("prod", 16'h0, PRODUCT);
        cmp("flags", 16'h0, FLAGS);
        apb(0, 12'h018, 0);
        cmp("slverr", 16'h1, e);
        apb(1, 12'h000, 32'h2);
        apb(1, 12'h004, 32'h2);
        exec(16'h0e5a);
        cmp("acc", 16'h5a, ACCUM);
        cmp("flags", 16'h0, FLAGS);
        apb(0, 12'h008, 0);
        cmp("acc reg", 16'h5a, q[15:0]);
        $display("test load done");
        exec(16'h6f20);
        cmp("m220", 16'h5a, mem.mem[12'h220]);
        exec(16'h6e30);
        cmp("m030", 16'h5a, mem.mem[12'h030]);
        exec(16'h6e80);
        cmp("mf80", 16'h5a, mem.mem[12'hf80]);
        apb(1, 12'h000, 32'h3);
        INDEX_BASE <= 12'h123;
        exec(16'h6e5f);
        cmp("m182", 16'h5a, mem.mem[12'h182]);
        exec(16'h6e60);
        cmp("mf60", 16'h5a, mem.mem[12'hf60]);
        apb(1, 12'h000, 32'h2);
        $display("test store done");
        exec(16'h0ee2);
        exec(16'h0dc4);
        cmp("prod", 16'had08, PRODUCT);
        cmp("acc", 16'he2, ACCUM);
        mem.mem[12'h210] = 8'hb5;
        exec(16'h0ec4);
        exec(16'h0310);
        cmp("prod", 16'h8a94, PRODUCT);
        cmp("acc", 16'hc4, ACCUM);
        cmp("m210", 16'hb5, mem.mem[12'h210]);
        $display("test multiply done");
        for (int i = 0; i < 4; i++) begin
            x = tab[i];
            r = 8'h00 - x;
            mem.mem[12'h240] = x;
            exec(16'h6d40);
            cmp("neg", r, mem.mem[12'h240]);
            cmp("flags", {r[7], x == 8'h80, r == 8'h00, x[3:0] == 4'h0, x == 8'h00}, FLAGS);
        end
        exec(16'h0e00);
        exec(16'h0d00);
        cmp("prod", 16'h0, PRODUCT);
        cmp("flags", 16'h10, FLAGS);
        exec(16'h0000);
        exec(16'hf123);
        cmp("acc", 16'h0, ACCUM);
        cmp("flags", 16'h10, FLAGS);
        $display("test negate and idle done");
        give_verdict;
    end
endmodule
